// File: src/radio_state_controller_defines.vh
`ifndef RADIO_STATE_CONTROLLER_DEFINES_VH
`define RADIO_STATE_CONTROLLER_DEFINES_VH

// Register byte offsets.
`define CMD_OFS 8'h00
`define CFG_A_OFS 8'h04
`define CFG_B_OFS 8'h08
`define CFG_C_OFS 8'h0c
`define FRONT_END_OFS 8'h10
`define CAL_TEST_OFS 8'h14
`define SYNTH_CAL_OFS 8'h18
`define SYMBOL_OFS 8'h1c
`define STATUS_OFS 8'h20

// Command register bit positions.
`define CMD_RX_BIT 0
`define CMD_TX_BIT 1
`define CMD_CAL_BIT 2
`define CMD_IDLE_BIT 3
`define CMD_FS_BIT 4

// Field encodings.
`define DEST_IDLE 2'h0
`define DEST_FS 2'h1
`define DEST_TX 2'h2
`define DEST_RX 2'h3
`define AUTOCAL_NEVER 2'h0
`define AUTOCAL_ON_START 2'h1
`define AUTOCAL_ON_RETURN 2'h2
`define AUTOCAL_FOURTH 2'h3
`define CCA_ALWAYS 2'h0
`define CCA_RSSI 2'h1
`define CCA_NOT_RX 2'h2
`define CCA_BOTH 2'h3
`define POWER_OOK 3'h1
`define CAL_TEST_SHORT 8'h09
`define PUMP_CAL_OFF 2'h0

// Reset values.
`define CFG_A_RST 2'h1
`define CFG_B_RST 6'h00
`define CFG_C_RST 1'h0
`define FRONT_END_RST 3'h0
`define CAL_TEST_RST 8'h0b
`define SYNTH_CAL_RST 2'h2
`define SYMBOL_RST 16'h0190

// Timing counts in crystal clock cycles; the on-off keying settle count is in symbols.
`define IDLE_RX_CYC 17'h007a1
`define IDLE_TX_CYC 17'h007a2
`define IDLE_CAL_TX_CYC 17'h007a1
`define RXTX_SWITCH_CYC 17'h0030e
`define RX_IDLE_CYC 17'h00002
`define MANUAL_CAL_CYC 17'h0011b
`define CAL_09_SHORT_CYC 17'h00eb4
`define CAL_0B_SHORT_CYC 17'h00fe9
`define CAL_09_LONG_CYC 17'h0484a
`define CAL_0B_LONG_CYC 17'h0497f
`define RSSI_RESP_CYC 17'h00040
`define OOK_SETTLE_SYMBOLS 4'h8

`endif

// File: src/radio_state_controller.v
// Functional notes
// - Receive and transmit strobes from the host move the controller into RX or TX.
// - Auto calibration: on start from idle, on each automatic return, or every fourth.
// - Calibrate strobe in idle runs 283 cycles plus synthesizer calibration time.
// - Idle strobe leaving RX or TX never triggers a calibration.
// - Each synthesizer calibration lasts a fixed count of crystal cycles.
// - RX holds until a packet is received or RX ends for no carrier.
// - After a packet, go to the after-receive destination: idle, synth ready, TX, RX.
// - Staying in RX after a packet hides signal strength for the response time.
// - TX holds until the packet is sent, then goes to the after-transmit destination.
// - Receive strobe during TX ends the transmission and switches to RX.
// - Transmit or synth strobes in RX are taken only when the channel is clear.
// - Idle strobe forces the idle state from any state.
// - With early end enabled, RX ends if the first valid carrier sample is low.
// - Under on-off keying a no-carrier sample counts only after eight symbols.
// - Idle to RX takes 1953 cycles, plus calibration time when calibrating.
// - Idle to TX or synth takes 1954 cycles, or 1953 plus calibration.
// - RX to TX takes 782 cycles; TX to RX adds a quarter symbol.
// - RX to idle takes 2 cycles, plus calibration when a return calibration applies.
// - TX to idle takes a quarter symbol, an eighth more under on-off keying.
// - Calibration length follows the test setting and pump current select table.
// - Pump current select 00 skips the charge pump stage, shortening calibration.
// - Channel clear rule: always, signal low, not receiving, or both of these.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "radio_state_controller_defines.vh"

module radio_state_controller #(
  parameter [16:0] CAL_09_LONG = `CAL_09_LONG_CYC,
  parameter [16:0] CAL_0B_LONG = `CAL_0B_LONG_CYC
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  // Modem events
  input wire packet_received_i,
  input wire packet_sent_i,
  input wire carrier_sense_i,
  input wire carrier_sense_valid_i,
  input wire receiving_packet_i,
  // Radio state
  output reg [4:0] radio_state_o,
  output reg cal_active_o,
  output reg rssi_valid_o
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_RX = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_FS = 5'h10;

  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;

  reg [1:0] auto_cal_policy_r;
  reg [1:0] channel_clear_rule_r;
  reg [1:0] after_receive_state_r;
  reg [1:0] after_transmit_state_r;
  reg early_rx_end_on_no_carrier_r;
  reg [2:0] power_table_index_r;
  reg [7:0] cal_test_setting_r;
  reg [1:0] pump_current_cal_select_r;
  reg [15:0] symbol_period_r;

  reg strobe_receive_r;
  reg strobe_transmit_r;
  reg strobe_calibrate_r;
  reg strobe_go_idle_r;
  reg strobe_synth_ready_tx_r;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [4:0] dest_r;
  reg [4:0] dest_nxt;
  reg [16:0] cnt_r;
  reg [16:0] cnt_nxt;
  reg cal_r;
  reg cal_nxt;
  reg [1:0] ret_cnt_r;
  reg [1:0] ret_cnt_nxt;
  reg rssi_restart;

  reg [15:0] sym_cnt_r;
  reg [3:0] rx_symbols_r;
  reg first_sample_r;
  reg [16:0] rssi_hold_r;

  reg start;
  reg [4:0] go_dest;
  reg [16:0] go_len;
  reg go_cal;
  reg [16:0] cal_cycles;
  reg channel_clear;
  reg [31:0] read_mux;
  reg read_err;

  wire setup_phase;
  wire write_access;
  wire [16:0] quarter_sym;
  wire [16:0] eighth_sym;
  wire is_ook;
  wire ret_cal;
  wire early_end;
  wire sym_tick;

  // The reset is released through two flops so release never races the clock.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // The slave always answers in the access cycle, so no wait states.
  assign pready_o = 1'b1;
  assign setup_phase = psel_i & ~penable_i;
  assign write_access = psel_i & penable_i & pwrite_i;

  always @* begin
    read_mux = 32'h00000000;
    read_err = 1'b0;
    case (paddr_i)
      `CMD_OFS: read_mux = 32'h00000000;
      `CFG_A_OFS: read_mux = {30'h00000000, auto_cal_policy_r};
      `CFG_B_OFS: read_mux = {26'h0000000, channel_clear_rule_r, after_receive_state_r, after_transmit_state_r};
      `CFG_C_OFS: read_mux = {31'h00000000, early_rx_end_on_no_carrier_r};
      `FRONT_END_OFS: read_mux = {29'h00000000, power_table_index_r};
      `CAL_TEST_OFS: read_mux = {24'h000000, cal_test_setting_r};
      `SYNTH_CAL_OFS: read_mux = {26'h0000000, pump_current_cal_select_r, 4'h0};
      `SYMBOL_OFS: read_mux = {16'h0000, symbol_period_r};
      `STATUS_OFS: read_mux = {18'h00000, ret_cnt_r, 2'h0, rssi_valid_o, cal_active_o, 3'h0, state_r};
      default: read_err = 1'b1;
    endcase
  end

  // Read data and the error answer are captured in the setup cycle and held through access.
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      prdata_o <= pwrite_i ? 32'h00000000 : read_mux;
      pslverr_o <= read_err;
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      auto_cal_policy_r <= `CFG_A_RST;
      {channel_clear_rule_r, after_receive_state_r, after_transmit_state_r} <= `CFG_B_RST;
      early_rx_end_on_no_carrier_r <= `CFG_C_RST;
      power_table_index_r <= `FRONT_END_RST;
      cal_test_setting_r <= `CAL_TEST_RST;
      pump_current_cal_select_r <= `SYNTH_CAL_RST;
      symbol_period_r <= `SYMBOL_RST;
      strobe_receive_r <= 1'b0;
      strobe_transmit_r <= 1'b0;
      strobe_calibrate_r <= 1'b0;
      strobe_go_idle_r <= 1'b0;
      strobe_synth_ready_tx_r <= 1'b0;
    end else begin
      strobe_receive_r <= 1'b0;
      strobe_transmit_r <= 1'b0;
      strobe_calibrate_r <= 1'b0;
      strobe_go_idle_r <= 1'b0;
      strobe_synth_ready_tx_r <= 1'b0;
      if (write_access) begin
        case (paddr_i)
          `CMD_OFS: begin
            strobe_receive_r <= pwdata_i[`CMD_RX_BIT];
            strobe_transmit_r <= pwdata_i[`CMD_TX_BIT];
            strobe_calibrate_r <= pwdata_i[`CMD_CAL_BIT];
            strobe_go_idle_r <= pwdata_i[`CMD_IDLE_BIT];
            strobe_synth_ready_tx_r <= pwdata_i[`CMD_FS_BIT];
          end
          `CFG_A_OFS: auto_cal_policy_r <= pwdata_i[1:0];
          `CFG_B_OFS: begin
            channel_clear_rule_r <= pwdata_i[5:4];
            after_receive_state_r <= pwdata_i[3:2];
            after_transmit_state_r <= pwdata_i[1:0];
          end
          `CFG_C_OFS: early_rx_end_on_no_carrier_r <= pwdata_i[0];
          `FRONT_END_OFS: power_table_index_r <= pwdata_i[2:0];
          `CAL_TEST_OFS: cal_test_setting_r <= pwdata_i[7:0];
          `SYNTH_CAL_OFS: pump_current_cal_select_r <= pwdata_i[5:4];
          `SYMBOL_OFS: symbol_period_r <= pwdata_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // Calibration length is a fixed table lookup, never data dependent.
  always @* begin
    if (cal_test_setting_r == `CAL_TEST_SHORT) begin
      cal_cycles = (pump_current_cal_select_r == `PUMP_CAL_OFF) ? `CAL_09_SHORT_CYC : CAL_09_LONG;
    end else begin
      cal_cycles = (pump_current_cal_select_r == `PUMP_CAL_OFF) ? `CAL_0B_SHORT_CYC : CAL_0B_LONG;
    end
  end

  always @* begin
    case (channel_clear_rule_r)
      `CCA_ALWAYS: channel_clear = 1'b1;
      `CCA_RSSI: channel_clear = ~carrier_sense_i;
      `CCA_NOT_RX: channel_clear = ~receiving_packet_i;
      default: channel_clear = ~carrier_sense_i & ~receiving_packet_i;
    endcase
  end

  assign quarter_sym = {3'h0, symbol_period_r[15:2]};
  assign eighth_sym = {4'h0, symbol_period_r[15:3]};
  assign is_ook = (power_table_index_r == `POWER_OOK);
  assign ret_cal = (auto_cal_policy_r == `AUTOCAL_ON_RETURN) |
                   ((auto_cal_policy_r == `AUTOCAL_FOURTH) & (ret_cnt_r == 2'h3));

  // Symbol timer, used to qualify carrier samples under on-off keying.
  assign sym_tick = (sym_cnt_r >= symbol_period_r) | (symbol_period_r == 16'h0000);
  assign early_end = early_rx_end_on_no_carrier_r & carrier_sense_valid_i & ~first_sample_r &
                     (~is_ook | (rx_symbols_r == `OOK_SETTLE_SYMBOLS)) & ~carrier_sense_i;

  always @* begin
    state_nxt = state_r;
    dest_nxt = dest_r;
    cal_nxt = cal_r;
    ret_cnt_nxt = ret_cnt_r;
    cnt_nxt = (cnt_r != 17'h00000) ? cnt_r - 17'h00001 : cnt_r;
    rssi_restart = 1'b0;
    start = 1'b0;
    go_dest = ST_IDLE;
    go_len = 17'h00001;
    go_cal = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (strobe_receive_r) begin
          start = 1'b1;
          go_dest = ST_RX;
          go_cal = (auto_cal_policy_r == `AUTOCAL_ON_START);
          go_len = go_cal ? `IDLE_RX_CYC + cal_cycles : `IDLE_RX_CYC;
        end else if (strobe_transmit_r | strobe_synth_ready_tx_r) begin
          start = 1'b1;
          go_dest = strobe_transmit_r ? ST_TX : ST_FS;
          go_cal = (auto_cal_policy_r == `AUTOCAL_ON_START);
          go_len = go_cal ? `IDLE_CAL_TX_CYC + cal_cycles : `IDLE_TX_CYC;
        end else if (strobe_calibrate_r) begin
          start = 1'b1;
          go_dest = ST_IDLE;
          go_cal = 1'b1;
          go_len = `MANUAL_CAL_CYC + cal_cycles;
        end
      end
      ST_WAIT: begin
        if (strobe_go_idle_r) begin
          state_nxt = ST_IDLE;
          cal_nxt = 1'b0;
          cnt_nxt = 17'h00000;
        end else if (cnt_r == 17'h00001) begin
          state_nxt = dest_r;
          cal_nxt = 1'b0;
        end
      end
      ST_RX: begin
        if (strobe_go_idle_r) begin
          start = 1'b1;
          go_dest = ST_IDLE;
          go_len = `RX_IDLE_CYC;
        end else if ((strobe_transmit_r | strobe_synth_ready_tx_r) & channel_clear) begin
          start = 1'b1;
          go_dest = strobe_transmit_r ? ST_TX : ST_FS;
          go_len = `RXTX_SWITCH_CYC;
        end else if (packet_received_i) begin
          case (after_receive_state_r)
            `DEST_IDLE: begin
              start = 1'b1;
              go_dest = ST_IDLE;
              go_cal = ret_cal;
              go_len = ret_cal ? `RX_IDLE_CYC + cal_cycles : `RX_IDLE_CYC;
              ret_cnt_nxt = ret_cnt_r + 2'h1;
            end
            `DEST_FS: begin
              start = 1'b1;
              go_dest = ST_FS;
              go_len = `RXTX_SWITCH_CYC;
            end
            `DEST_TX: begin
              start = 1'b1;
              go_dest = ST_TX;
              go_len = `RXTX_SWITCH_CYC;
            end
            default: rssi_restart = 1'b1;
          endcase
        end else if (early_end) begin
          start = 1'b1;
          go_dest = ST_IDLE;
          go_cal = ret_cal;
          go_len = ret_cal ? `RX_IDLE_CYC + cal_cycles : `RX_IDLE_CYC;
          ret_cnt_nxt = ret_cnt_r + 2'h1;
        end
      end
      ST_TX: begin
        if (strobe_go_idle_r) begin
          start = 1'b1;
          go_dest = ST_IDLE;
          go_len = is_ook ? quarter_sym + eighth_sym : quarter_sym;
        end else if (strobe_receive_r) begin
          start = 1'b1;
          go_dest = ST_RX;
          go_len = `RXTX_SWITCH_CYC + quarter_sym;
        end else if (packet_sent_i) begin
          case (after_transmit_state_r)
            `DEST_IDLE: begin
              start = 1'b1;
              go_dest = ST_IDLE;
              go_cal = ret_cal;
              go_len = (is_ook ? quarter_sym + eighth_sym : quarter_sym) + (ret_cal ? cal_cycles : 17'h00000);
              ret_cnt_nxt = ret_cnt_r + 2'h1;
            end
            `DEST_FS: begin
              start = 1'b1;
              go_dest = ST_FS;
              go_len = quarter_sym;
            end
            `DEST_RX: begin
              start = 1'b1;
              go_dest = ST_RX;
              go_len = `RXTX_SWITCH_CYC + quarter_sym;
            end
            default: state_nxt = ST_TX;
          endcase
        end
      end
      ST_FS: begin
        if (strobe_go_idle_r) begin
          state_nxt = ST_IDLE;
        end else if (strobe_transmit_r) begin
          start = 1'b1;
          go_dest = ST_TX;
        end else if (strobe_receive_r) begin
          start = 1'b1;
          go_dest = ST_RX;
          go_len = `RXTX_SWITCH_CYC;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A strobe in IDLE with a calibrating idle-to-idle path still passes through the wait state.
    if (start) begin
      state_nxt = ST_WAIT;
      dest_nxt = go_dest;
      cal_nxt = go_cal;
      cnt_nxt = (go_len == 17'h00000) ? 17'h00001 : go_len;
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      dest_r <= ST_IDLE;
      cnt_r <= 17'h00000;
      cal_r <= 1'b0;
      ret_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      dest_r <= dest_nxt;
      cnt_r <= cnt_nxt;
      cal_r <= cal_nxt;
      ret_cnt_r <= ret_cnt_nxt;
    end
  end

  // RX bookkeeping restarts whenever RX is entered or a packet keeps the radio in RX.
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sym_cnt_r <= 16'h0000;
      rx_symbols_r <= 4'h0;
      first_sample_r <= 1'b0;
      rssi_hold_r <= 17'h00000;
    end else if ((state_nxt == ST_RX) & ((state_r != ST_RX) | rssi_restart)) begin
      sym_cnt_r <= 16'h0000;
      rx_symbols_r <= 4'h0;
      first_sample_r <= 1'b0;
      rssi_hold_r <= `RSSI_RESP_CYC;
    end else if (state_r == ST_RX) begin
      sym_cnt_r <= sym_tick ? 16'h0000 : sym_cnt_r + 16'h0001;
      if (sym_tick & (rx_symbols_r != `OOK_SETTLE_SYMBOLS)) begin
        rx_symbols_r <= rx_symbols_r + 4'h1;
      end
      if (carrier_sense_valid_i & (~is_ook | (rx_symbols_r == `OOK_SETTLE_SYMBOLS))) begin
        first_sample_r <= 1'b1;
      end
      if (rssi_hold_r != 17'h00000) begin
        rssi_hold_r <= rssi_hold_r - 17'h00001;
      end
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      radio_state_o <= ST_IDLE;
      cal_active_o <= 1'b0;
      rssi_valid_o <= 1'b0;
    end else begin
      radio_state_o <= state_nxt;
      cal_active_o <= cal_nxt & (state_nxt == ST_WAIT);
      rssi_valid_o <= (state_r == ST_RX) & (state_nxt == ST_RX) & ~rssi_restart &
                      (rssi_hold_r <= 17'h00001);
    end
  end

endmodule
`default_nettype wire

// File: test/radio_state_controller_properties.sv
`timescale 1ns/10ps
`default_nettype none
module radio_state_controller_properties (
  // Clock, reset and bus
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  // Modem events
  input wire packet_received_i,
  input wire packet_sent_i,
  input wire carrier_sense_valid_i,
  // Radio state
  input wire [4:0] radio_state_o,
  input wire cal_active_o,
  input wire rssi_valid_o
);
  localparam [4:0] IDLE = 5'h01;
  localparam [4:0] WAITS = 5'h02;
  localparam [4:0] RX = 5'h04;
  localparam [4:0] TX = 5'h08;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire wr = psel_i & penable_i & pwrite_i;
  reg [4:0] from_r;
  reg [15:0] wait_len_r;
  // Remembers where each wait started and how long it has lasted.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      from_r <= IDLE;
      wait_len_r <= 16'h0000;
    end else begin
      if (radio_state_o != WAITS) from_r <= radio_state_o;
      wait_len_r <= (radio_state_o == WAITS) ? wait_len_r + 16'h0001 : 16'h0000;
    end
  end
  chk_state_onehot: assert property ($onehot(radio_state_o)) else $error("state not one-hot");
  chk_cal_in_wait: assert property (cal_active_o |-> radio_state_o == WAITS) else $error("cal outside wait");
  chk_rx_holds: assert property (radio_state_o == RX && !packet_received_i && !carrier_sense_valid_i
    && !$past(wr) |=> radio_state_o == RX) else $error("rx left without cause");
  chk_tx_holds: assert property (radio_state_o == TX && !packet_sent_i && !$past(wr)
    |=> radio_state_o == TX) else $error("tx left without cause");
  chk_rssi_in_rx: assert property (rssi_valid_o |-> radio_state_o == RX) else $error("rssi valid off rx");
  chk_rssi_drop: assert property (radio_state_o == RX && packet_received_i |=> !rssi_valid_o)
    else $error("rssi kept after packet");
  chk_rx_entry_blank: assert property ($rose(radio_state_o == RX) |-> !rssi_valid_o [*8])
    else $error("rssi valid at rx entry");
  chk_rx_tx_time: assert property (radio_state_o == TX && $past(radio_state_o) == WAITS && from_r == RX
    |-> wait_len_r == 16'h030e) else $error("rx to tx time wrong");
  chk_rx_idle_time: assert property (radio_state_o == IDLE && $past(radio_state_o) == WAITS && from_r == RX
    && !$past(cal_active_o) |-> wait_len_r == 16'h0002) else $error("rx to idle time wrong");
  chk_idle_rx_time: assert property (radio_state_o == RX && $past(radio_state_o) == WAITS && from_r == IDLE
    && !$past(cal_active_o) |-> wait_len_r == 16'h07a1) else $error("idle to rx time wrong");
  cover property ($rose(cal_active_o));
  cover property (radio_state_o == RX && packet_received_i);
  cover property ($rose(radio_state_o == 5'h10));
endmodule
bind radio_state_controller radio_state_controller_properties i_props (
  .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .packet_received_i(packet_received_i), .packet_sent_i(packet_sent_i),
  .carrier_sense_valid_i(carrier_sense_valid_i), .radio_state_o(radio_state_o),
  .cal_active_o(cal_active_o), .rssi_valid_o(rssi_valid_o));
`default_nettype wire

// File: test/host_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model (
  // Clock and bus answers
  input wire logic clock_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  // Bus requests
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released data is scrambled so nothing relies on a stale word.
    pwdata_o <= ~d;
  endtask
  // The idle strobe is accepted from any state, so it is the host's abort.
  task automatic strobe(input int b);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 8'h00, 32'h00000001 << b, q, e);
  endtask
endmodule
`default_nettype wire

// File: test/tb_radio_state_controller.sv
`timescale 1ns/10ps
`default_nettype none
module tb_radio_state_controller;
  localparam [4:0] IDLE = 5'h01, WAITS = 5'h02, RX = 5'h04, TX = 5'h08, FS = 5'h10;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cs = 1'b1;
  logic rcv = 1'b0;
  logic [2:0] ev = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, cal_act, rssi_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] rs = 32'h00006e2b;
  logic [4:0] st;
  logic [4:0] dst[3] = '{IDLE, FS, TX};
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int q_rst[$] = '{1, 0, 0, 0, 11, 32, 400};
  int nd[3] = '{2, 782, 782};
  int nb[3] = '{1954, 783, 787};
  int calt[4] = '{3764, 40, 4073, 50};
  radio_state_controller #(.CAL_09_LONG(17'h00028), .CAL_0B_LONG(17'h00032)) i_radio_state_controller (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .packet_received_i(ev[0]), .packet_sent_i(ev[1]), .carrier_sense_i(cs), .carrier_sense_valid_i(ev[2]),
    .receiving_packet_i(rcv), .radio_state_o(st), .cal_active_o(cal_act), .rssi_valid_o(rssi_v));
  host_mcu_model host (.clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, d);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic idle_n(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse(input int b);
    @(posedge clock_i);
    ev[b] <= 1'b1;
    @(posedge clock_i);
    ev <= 3'h0;
  endtask
  // Counts edges until the destination follows a wait; the first wait cycle shows whether it calibrates.
  task automatic go(input logic [4:0] dest, input int n, input logic cal);
    int k;
    logic sw;
    k = 0;
    sw = 1'b0;
    while (!(sw && st === dest) && k < 9000) begin
      @(posedge clock_i);
      #1;
      k++;
      if (!sw && st === WAITS) chk(cal_act, cal);
      sw = sw | (st === WAITS);
    end
    chk(k, n);
    chk(st, dest);
  endtask
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    idle_n(3);
    chk(st, IDLE);
    for (int i = 0; i < 7; i++) rd(8'h04 + 8'(4 * i), q_rst[i], 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    r = xs() & 32'h0000ffff;
    wr(8'h1c, r);
    rd(8'h1c, r, 1'b0);
    wr(8'h1c, 32'h00000010);
    wr(8'h04, 32'h0);
    $display("test registers done");
    host.strobe(0);
    go(RX, 1954, 1'b0);
    idle_n(70 + int'(xs() & 32'h1f));
    chk(rssi_v, 1'b1);
    chk(st, RX);
    wr(8'h08, 32'h10);
    host.strobe(1);
    idle_n(800);
    chk(st, RX);
    @(posedge clock_i) cs <= 1'b0;
    host.strobe(1);
    go(TX, 783, 1'b0);
    wr(8'h08, 32'h03);
    idle_n(20);
    chk(st, TX);
    pulse(1);
    go(RX, 786, 1'b0);
    for (int d = 0; d < 3; d++) begin
      wr(8'h08, 32'(d << 2));
      pulse(0);
      go(dst[d], nd[d], 1'b0);
      host.strobe(0);
      go(RX, nb[d], 1'b0);
    end
    wr(8'h08, 32'h0c);
    pulse(0);
    #1;
    chk(rssi_v, 1'b0);
    chk(st, RX);
    wr(8'h08, 32'h2c);
    @(posedge clock_i) rcv <= 1'b1;
    host.strobe(1);
    idle_n(5);
    chk(st, RX);
    @(posedge clock_i) rcv <= 1'b0;
    host.strobe(1);
    go(TX, 783, 1'b0);
    host.strobe(0);
    go(RX, 787, 1'b0);
    $display("test rx tx done");
    wr(8'h04, 32'h2);
    host.strobe(3);
    go(IDLE, 3, 1'b0);
    host.strobe(0);
    go(RX, 1954, 1'b0);
    wr(8'h0c, 32'h1);
    pulse(2);
    go(IDLE, 52, 1'b1);
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h1);
    host.strobe(0);
    go(RX, 2004, 1'b1);
    host.strobe(3);
    go(IDLE, 3, 1'b0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h1);
    host.strobe(1);
    go(TX, 1955, 1'b0);
    pulse(1);
    go(IDLE, 6, 1'b0);
    host.strobe(4);
    go(FS, 1955, 1'b0);
    host.strobe(3);
    idle_n(2);
    chk(st, IDLE);
    $display("test policies done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h14, c[1] ? 32'h0b : 32'h09);
      wr(8'h18, c[0] ? 32'h20 : 32'h00);
      host.strobe(2);
      go(IDLE, 284 + calt[c], 1'b1);
    end
    $display("test calibration done");
    end_sim();
  end
endmodule
`default_nettype wire
